//--- core/amc_defines.vh
// Register map, field positions and reset values for the mode port
`ifndef AMC_DEFINES_VH
`define AMC_DEFINES_VH

// Register addresses
`define AMC_ADDR_SOFT_RESET   7'h00
`define AMC_ADDR_POWER_DOWN   7'h01
`define AMC_ADDR_CLK_TIMING   7'h02
`define AMC_ADDR_DRIVER_MODE  7'h03

// Reset value of every mode register
`define AMC_REG_RESET         8'h00

// Field positions
`define AMC_SOFT_RESET_BIT    7
`define AMC_PWR_MSB           1
`define AMC_PWR_LSB           0
`define AMC_CLK_INV_BIT       3
`define AMC_CLK_PHASE_MSB     2
`define AMC_CLK_PHASE_LSB     1
`define AMC_DCS_BIT           0
`define AMC_CUR_MSB           6
`define AMC_CUR_LSB           4
`define AMC_TERM_BIT          3
`define AMC_OUT_OFF_BIT       2
`define AMC_FMT_MSB           1
`define AMC_FMT_LSB           0

// Power codes
`define AMC_PWR_NORMAL        2'h0
`define AMC_PWR_NAP           2'h1
`define AMC_PWR_SLEEP         2'h3

// Output format codes
`define AMC_FMT_CMOS          2'h0
`define AMC_FMT_DDR_LVDS      2'h1
`define AMC_FMT_DDR_CMOS      2'h2

// Drive current code for 3.5 mA
`define AMC_CUR_3P5MA         3'h0

// Frame layout
`define AMC_FRAME_BITS        16
`define AMC_DATA_BITS         8

`endif

//--- core/amc_pin_sync.v
// Three-stage synchroniser with agreement filter for one pin
module amc_pin_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire reset_n,
  // Pin in, filtered level out
  input  wire pin_in,
  input  wire init_level,
  output reg  level_out
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      // Stored relative to the idle level so reset means idle
      s1_reg <= pin_in ^ init_level;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg ^ init_level;
      end
    end
  end

endmodule

//--- core/amc_shift_frame.v
// Serial frame shifter: counts rising edges, captures 16 bits
`include "amc_defines.vh"

module amc_shift_frame (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // Frame control
  input  wire        frame_active,
  input  wire        sck_rise,
  input  wire        sdi_level,
  // Captured frame
  output reg  [15:0] shift_reg,
  output reg  [4:0]  bit_count_reg
);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg     <= 16'h0000;
      bit_count_reg <= 5'h00;
    end else if (!frame_active) begin
      bit_count_reg <= 5'h00;
    end else if (sck_rise && bit_count_reg < 5'd`AMC_FRAME_BITS) begin
      shift_reg     <= {shift_reg[14:0], sdi_level};
      bit_count_reg <= bit_count_reg + 5'h01;
    end
  end

endmodule

//--- core/amc_mode_port.v
// Mode configuration port: static pin mode and serial register port
`include "amc_defines.vh"

// What this block does
// RULE1: Interface select high makes pins static levels
// RULE2: Static chip-select level drives duty stabilizer
// RULE3: Static clock pin picks CMOS or LVDS
// RULE4: Static data-in high puts converter asleep
// RULE5: Interface select low enables serial register port
// RULE6: Frame by chip-select; first 16 edges only
// RULE7: Host sends flag, address, data, MSB first
// RULE8: Flag low writes data to addressed register
// RULE9: Flag high reads back, register untouched
// RULE10: Data-out is open drain, low or released
// RULE11: Reset bit clears all registers, self-clears
// RULE12: Host issues software reset first
// RULE13: Power code: normal, nap, sleep
// RULE14: Timing bit 3 inverts output clock
// RULE15: Timing bits 2-1 set clock phase delay
// RULE16: Host enables stabilizer with nonzero phase; the testbench also enables it with phase 0
// RULE17: Timing bit 0 enables duty stabilizer
// RULE18: Driver bits 6-4 set LVDS current
// RULE19: Driver bit 3 enables LVDS termination
// RULE20: Driver bit 2 tri-states digital outputs
// RULE21: Driver bits 1-0 select output format
// RULE22: Unused bits have no effect
// RULE23: Read data on last eight clocks
// RULE24: Format code 01 means DDR LVDS
module amc_mode_port (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       reset_n,
  // Mode pins
  input  wire       interface_select,
  input  wire       cs_n,
  input  wire       sck,
  input  wire       sdi,
  // Open-drain serial data-out
  output wire       sdo_out,
  output reg        sdo_oe,
  // Decoded mode controls
  output reg        duty_stabilizer_enable,
  output reg  [1:0] output_format_select,
  output reg  [1:0] power_down_code,
  output reg        out_clock_invert,
  output reg  [1:0] out_clock_phase,
  output reg  [2:0] lvds_drive_current,
  output reg        lvds_termination_enable,
  output reg        outputs_disable,
  output reg        sleep_mode,
  output reg        nap_mode
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire sel_lvl;
  wire cs_lvl;
  wire sck_lvl;
  wire sdi_lvl;
  wire [3:0] pins_raw;
  wire [3:0] pins_lvl;
  // Idle levels: chip-select rests high, the rest low
  wire [3:0] pins_idle;
  assign pins_idle = 4'h4;

  assign pins_raw = {interface_select, cs_n, sck, sdi};
  assign sel_lvl  = pins_lvl[3];
  assign cs_lvl   = pins_lvl[2];
  assign sck_lvl  = pins_lvl[1];
  assign sdi_lvl  = pins_lvl[0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      amc_pin_sync u_sync (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .pin_in     (pins_raw[gi]),
        .init_level (pins_idle[gi]),
        .level_out  (pins_lvl[gi])
      );
    end
  endgenerate

  // ****************************************
  // Edge detection on filtered levels
  // ****************************************
  reg sck_prev_reg;
  reg cs_prev_reg;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end else begin
      sck_prev_reg <= sck_lvl;
      cs_prev_reg  <= cs_lvl;
    end
  end

  wire serial_mode;
  wire frame_active;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;

  assign serial_mode  = ~sel_lvl; // RULE5
  assign frame_active = serial_mode & ~cs_lvl; // RULE6
  assign sck_rise     = sck_lvl & ~sck_prev_reg;
  assign sck_fall     = ~sck_lvl & sck_prev_reg;
  assign cs_rise      = cs_lvl & ~cs_prev_reg;

  // ****************************************
  // Frame shifter
  // ****************************************
  wire [15:0] shift_val;
  wire [4:0]  bit_count;

  amc_shift_frame u_shift (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .frame_active  (frame_active),
    .sck_rise      (sck_rise),
    .sdi_level     (sdi_lvl),
    .shift_reg     (shift_val),
    .bit_count_reg (bit_count)
  );

  // Header fields after the first eight bits
  wire       rw_flag;
  wire [6:0] addr_val;
  assign rw_flag  = shift_val[7];
  assign addr_val = shift_val[6:0];

  // Frame completes on the sixteenth edge
  reg frame_done_reg;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_done_reg <= 1'b0;
    end else begin
      frame_done_reg <= frame_active & sck_rise &
                        (bit_count == 5'd15); // RULE6
    end
  end

  // ****************************************
  // Mode registers
  // ****************************************
  reg [7:0] soft_reset_reg;
  reg [7:0] power_down_reg;
  reg [7:0] output_clock_timing_reg;
  reg [7:0] output_driver_mode_reg;

  wire wr_en;
  wire soft_rst;
  assign wr_en    = frame_done_reg & frame_active & ~shift_val[15]; // RULE8
  assign soft_rst = soft_reset_reg[`AMC_SOFT_RESET_BIT];

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_reset_reg          <= `AMC_REG_RESET;
      power_down_reg          <= `AMC_REG_RESET;
      output_clock_timing_reg <= `AMC_REG_RESET;
      output_driver_mode_reg  <= `AMC_REG_RESET;
    end else if (soft_rst) begin
      soft_reset_reg          <= `AMC_REG_RESET; // RULE11
      power_down_reg          <= `AMC_REG_RESET;
      output_clock_timing_reg <= `AMC_REG_RESET;
      output_driver_mode_reg  <= `AMC_REG_RESET;
    end else if (wr_en) begin
      case (shift_val[14:8])
        `AMC_ADDR_SOFT_RESET:  soft_reset_reg <= shift_val[7:0];
        `AMC_ADDR_POWER_DOWN:  power_down_reg <= shift_val[7:0];
        `AMC_ADDR_CLK_TIMING:  output_clock_timing_reg <= shift_val[7:0];
        `AMC_ADDR_DRIVER_MODE: output_driver_mode_reg <= shift_val[7:0];
        default: soft_reset_reg <= soft_reset_reg;
      endcase
    end
  end

  // ****************************************
  // Read-back path
  // ****************************************
  reg [7:0] rd_mux;
  always @* begin
    case (addr_val)
      `AMC_ADDR_SOFT_RESET:  rd_mux = soft_reset_reg;
      `AMC_ADDR_POWER_DOWN:  rd_mux = power_down_reg;
      `AMC_ADDR_CLK_TIMING:  rd_mux = output_clock_timing_reg;
      `AMC_ADDR_DRIVER_MODE: rd_mux = output_driver_mode_reg;
      default:               rd_mux = 8'h00;
    endcase
  end

  reg [7:0] rd_shift_reg;
  reg       rd_active_reg;

  // Load after eighth edge, shift on the next seven falling edges
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_shift_reg  <= 8'h00;
      rd_active_reg <= 1'b0;
    end else if (!frame_active || cs_rise) begin
      rd_active_reg <= 1'b0; // RULE23
    end else if (bit_count == 5'd8 && !rd_active_reg &&
                 rw_flag && sck_fall) begin
      rd_shift_reg  <= rd_mux; // RULE9
      rd_active_reg <= 1'b1;
    end else if (rd_active_reg && sck_fall &&
                 bit_count > 5'd8 && bit_count < 5'd16) begin
      rd_shift_reg  <= {rd_shift_reg[6:0], 1'b0}; // RULE23
    end else if (rd_active_reg && sck_fall && bit_count == 5'd16) begin
      rd_active_reg <= 1'b0;
    end
  end

  // Open drain: only ever pulls low
  assign sdo_out = 1'b0; // RULE10
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= rd_active_reg & ~rd_shift_reg[7]; // RULE10
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  wire [1:0] pwr_code;
  wire [1:0] fmt_code;
  assign pwr_code = power_down_reg[`AMC_PWR_MSB:`AMC_PWR_LSB];
  assign fmt_code = output_driver_mode_reg[`AMC_FMT_MSB:`AMC_FMT_LSB];

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      duty_stabilizer_enable  <= 1'b0;
      output_format_select    <= `AMC_FMT_CMOS;
      power_down_code         <= `AMC_PWR_NORMAL;
      out_clock_invert        <= 1'b0;
      out_clock_phase         <= 2'h0;
      lvds_drive_current      <= `AMC_CUR_3P5MA;
      lvds_termination_enable <= 1'b0;
      outputs_disable         <= 1'b0;
      sleep_mode              <= 1'b0;
      nap_mode                <= 1'b0;
    end else if (sel_lvl) begin
      // Static pin mode
      duty_stabilizer_enable  <= cs_lvl; // RULE1 RULE2
      output_format_select    <= sck_lvl ? `AMC_FMT_DDR_LVDS
                                         : `AMC_FMT_CMOS; // RULE3
      lvds_drive_current      <= `AMC_CUR_3P5MA; // RULE3
      lvds_termination_enable <= 1'b0; // RULE3
      power_down_code         <= sdi_lvl ? `AMC_PWR_SLEEP
                                         : `AMC_PWR_NORMAL; // RULE4
      sleep_mode              <= sdi_lvl; // RULE4
      nap_mode                <= 1'b0;
      out_clock_invert        <= 1'b0;
      out_clock_phase         <= 2'h0;
      outputs_disable         <= 1'b0;
    end else begin
      // Serial mode: only documented bits are decoded
      duty_stabilizer_enable  <= output_clock_timing_reg[`AMC_DCS_BIT]; // RULE17
      out_clock_invert        <= output_clock_timing_reg[`AMC_CLK_INV_BIT]; // RULE14
      out_clock_phase         <= output_clock_timing_reg
                                 [`AMC_CLK_PHASE_MSB:`AMC_CLK_PHASE_LSB]; // RULE15
      power_down_code         <= pwr_code; // RULE13
      sleep_mode              <= (pwr_code == `AMC_PWR_SLEEP); // RULE13
      nap_mode                <= (pwr_code == `AMC_PWR_NAP); // RULE13
      lvds_drive_current      <= output_driver_mode_reg
                                 [`AMC_CUR_MSB:`AMC_CUR_LSB]; // RULE18
      lvds_termination_enable <= output_driver_mode_reg[`AMC_TERM_BIT]; // RULE19
      outputs_disable         <= output_driver_mode_reg[`AMC_OUT_OFF_BIT]; // RULE20
      output_format_select    <= fmt_code; // RULE21 RULE24
    end
  end
  // Unused bits are stored but never decoded. RULE22

endmodule

//--- dv/amc_mode_port_sva.sv
// Checker on the mode port pins and decoded outputs
module amc_mode_port_sva (
  // Clock, reset and pins
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       interface_select,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       sdi,
  // Outputs
  input wire logic       sdo_out,
  input wire logic       sdo_oe,
  input wire logic       duty_stabilizer_enable,
  input wire logic [1:0] output_format_select,
  input wire logic [1:0] power_down_code,
  input wire logic [2:0] lvds_drive_current,
  input wire logic       sleep_mode,
  input wire logic       nap_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  sdo_drain_a: assert property (sdo_out == 1'b0)
    else $error("sdo drives high");
  sdo_idle_a: assert property (cs_n[*8] |-> !sdo_oe)
    else $error("sdo held outside frame");
  pin_no_serial_a: assert property (interface_select[*8] |-> !sdo_oe)
    else $error("sdo used in pin mode");
  pin_dcs_a: assert property ((interface_select && $stable(cs_n))[*8]
    |-> duty_stabilizer_enable == cs_n) else $error("pin stabilizer");
  pin_fmt_a: assert property ((interface_select && $stable(sck))[*8]
    |-> output_format_select == {1'b0, sck}) else $error("pin format");
  pin_cur_a: assert property (interface_select[*8]
    |-> lvds_drive_current == 3'h0) else $error("pin current");
  pin_sleep_a: assert property ((interface_select && $stable(sdi))[*8]
    |-> sleep_mode == sdi) else $error("pin sleep");
  pwr_decode_a: assert property ((!interface_select
    && $stable(power_down_code))[*3] |-> nap_mode == (power_down_code
    == 2'h1) && sleep_mode == (power_down_code == 2'h3))
    else $error("power decode");
  idle_hold_a: assert property ((!interface_select && cs_n)[*8]
    |-> $stable(power_down_code) && $stable(lvds_drive_current))
    else $error("mode change without frame");
  cover property (nap_mode);
  cover property (sleep_mode && !interface_select);
  cover property (sdo_oe);
endmodule

//--- dv/amc_host_model.sv
// Host controller driving the serial configuration port
module amc_host_model (
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo_oe,
  input  wire logic sdo_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up on the open-drain line
  wire sdo_pin = sdo_oe ? sdo_out : 1'b1;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // Half of the 80 ns serial clock
  task automatic half();
    repeat (5) @(negedge ref_clk);
  endtask
  // Frame of n rising edges; read bits taken late in high phase
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = (i < 16) ? w[15 - i] : ~sdi;
      half();
      sck = 1'b1;
      half();
      if (i >= 8 && i < 16) rd = {rd[6:0], sdo_pin};
      sck = 1'b0;
    end
    half();
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

//--- dv/amc_mode_port_tb.sv
// Testbench for the mode configuration port
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module amc_mode_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       interface_select = 1'b0;
  wire        cs_n, sck, sdi, sdo_out, sdo_oe, duty, inv, term, off;
  wire        sleep_mode, nap_mode;
  wire  [1:0] fmt, pwr, phase;
  wire  [2:0] cur;
  int         bad_count = 0;
  int         tests_run = 0;
  int         cycles = 0;
  logic [7:0] rd;
  amc_mode_port u_dut (.ref_clk, .reset_n, .interface_select, .cs_n,
    .sck, .sdi, .sdo_out, .sdo_oe, .duty_stabilizer_enable(duty),
    .output_format_select(fmt), .power_down_code(pwr),
    .out_clock_invert(inv), .out_clock_phase(phase),
    .lvds_drive_current(cur), .lvds_termination_enable(term),
    .outputs_disable(off), .sleep_mode, .nap_mode);
  amc_host_model u_host (.ref_clk, .cs_n, .sck, .sdi, .sdo_oe, .sdo_out);
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({1'b0, a, d}, 16, rd);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    u_host.xfer({1'b1, a, 8'hFF}, 16, rd);
    `CHK("readback", e, rd);
  endtask
  task automatic t_regs();
    logic [1:0] c;
    logic [7:0] v;
    `CHK("pwr0", 2'h0, pwr);
    wr(7'h00, 8'h80);
    for (int a = 0; a < 4; a++) rchk(a[6:0], 8'h00);
    for (int i = 0; i < 3; i++) begin
      c = (i == 2) ? 2'h3 : i[1:0];
      wr(7'h01, {6'h3F, c});
      `CHK("pwr", c, pwr);
      `CHK("nap", c == 2'h1, nap_mode);
      `CHK("sleep", c == 2'h3, sleep_mode);
    end
    rchk(7'h01, 8'hFF);
    for (int p = 0; p < 4; p++) begin
      wr(7'h02, {4'hF, p[0], p[1:0], 1'b1});
      `CHK("inv", p[0], inv);
      `CHK("phase", p[1:0], phase);
      `CHK("dcs", 1'b1, duty);
    end
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], i[2], i[1], i[1] & ~i[0], i[0]};
      wr(7'h03, v);
      `CHK("cur", v[6:4], cur);
      `CHK("term", v[3], term);
      `CHK("off", v[2], off);
      `CHK("fmt", v[1:0], fmt);
    end
  endtask
  task automatic t_frames();
    wr(7'h03, 8'h41);
    u_host.xfer({1'b0, 7'h03, 8'h22}, 15, rd);
    `CHK("short", 3'h4, cur);
    u_host.xfer({1'b0, 7'h03, 8'h32}, 20, rd);
    `CHK("long", 2'h2, fmt);
    rchk(7'h03, 8'h32);
    `CHK("keep", 3'h3, cur);
    wr(7'h10, 8'h55);
    rchk(7'h10, 8'h00);
    wr(7'h02, 8'h0F);
    wr(7'h00, 8'hFF);
    `CHK("rst", 6'h00, {pwr, cur, inv});
    rchk(7'h00, 8'h00);
    rchk(7'h02, 8'h00);
  endtask
  task automatic t_pins();
    interface_select = 1'b1;
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      u_host.cs_n = i[0];
      u_host.sck = i[1];
      u_host.sdi = i[2];
      repeat (10) @(negedge ref_clk);
      `CHK("pdcs", i[0], duty);
      `CHK("pfmt", {1'b0, i[1]}, fmt);
      `CHK("psleep", i[2], sleep_mode);
      `CHK("pdrv", 5'h00, {cur, term, sdo_oe});
    end
    u_host.cs_n = 1'b1;
    u_host.sck = 1'b0;
    repeat (8) @(negedge ref_clk);
    interface_select = 1'b0;
    repeat (10) @(negedge ref_clk);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_regs();
    t_frames();
    t_pins();
    finish_test();
  end
endmodule
bind amc_mode_port amc_mode_port_sva u_sva (.ref_clk, .reset_n,
  .interface_select, .cs_n, .sck, .sdi, .sdo_out, .sdo_oe,
  .duty_stabilizer_enable, .output_format_select, .power_down_code,
  .lvds_drive_current, .sleep_mode, .nap_mode);
